// ### verilog/fph_pkg.sv
// Shared constants, types and helpers for the flash power and protection control block
`default_nettype none
package fph_pkg;
  // Clock rate of the system clock
  localparam int CLK_MHZ          = 100;
  // Array organisation
  localparam int ARRAY_BYTES      = 262144;
  localparam int SECTOR_BYTES     = 65536;
  localparam int PAGE_BYTES       = 256;
  // Instruction codes
  localparam logic [7:0] CMD_LATCH_SET   = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE= 8'h01;
  localparam logic [7:0] CMD_ARRAY_READ  = 8'h03;
  localparam logic [7:0] CMD_PAGE_WRITE  = 8'h02;
  localparam logic [7:0] CMD_BLOCK_CLEAR = 8'hd8;
  localparam logic [7:0] CMD_CHIP_CLEAR  = 8'hc7;
  localparam logic [7:0] CMD_SLEEP_ENTER = 8'hb9;
  localparam logic [7:0] CMD_WAKE        = 8'hab;
  // Status byte bit positions
  localparam int ST_BUSY_POS      = 0;
  localparam int ST_LATCH_POS     = 1;
  localparam int ST_GUARD_LO_POS  = 2;
  localparam int ST_GUARD_HI_POS  = 3;
  localparam int ST_LOCK_POS      = 7;
  // Reset image of the retained status bits
  localparam logic [1:0] GUARD_RST = 2'h0;
  localparam logic       LOCK_RST  = 1'h0;
  // Signature byte: value is arbitrary
  localparam logic [7:0] SIGNATURE = 8'h5a;
  // Status-write cycle time, least time rounds up
  localparam int STATUS_WRITE_NS  = 1000;
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * CLK_MHZ + 999) / 1000;
  // Pin vector positions and idle levels
  localparam int PIN_CS           = 0;
  localparam int PIN_CLK          = 1;
  localparam int PIN_SDI          = 2;
  localparam int PIN_PAUSE        = 3;
  localparam int PIN_GUARD        = 4;
  localparam logic [4:0] PIN_IDLE = 5'h19;

  // Internal cycle kinds, Gray along idle->status->program->sector->chip
  typedef enum logic [2:0] {
    CYC_IDLE    = 3'h0,
    CYC_STATUS  = 3'h1,
    CYC_PROGRAM = 3'h3,
    CYC_SECTOR  = 3'h2,
    CYC_CHIP    = 3'h6
  } fph_cycle_t;

  // Power mode seen at the top
  typedef enum logic [1:0] {
    PWR_STANDBY = 2'h0,
    PWR_ACTIVE  = 2'h1,
    PWR_SLEEP   = 2'h3
  } fph_power_t;

  // Sector shielded by the two guard bits
  function automatic logic fph_guarded(input logic [1:0] sector, input logic hi, input logic lo);
    logic g;
    g = 1'b0;
    case ({hi, lo})
      2'b01:   g = (sector == 2'h3);
      2'b10:   g = sector[1];
      2'b11:   g = 1'b1;
      default: g = 1'b0;
    endcase
    return g;
  endfunction : fph_guarded
endpackage : fph_pkg
`default_nettype wire

// ### verilog/fph_link_if.sv
// Interface between the pin front end and the control core
`timescale 1ns/10ps
`default_nettype none
interface fph_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi;
  logic selected;
  logic deselect;
  logic paused;
  logic guard_n;

  modport fe   (output sclk_rise, output sclk_fall, output sdi, output selected,
                output deselect, output paused, output guard_n);
  modport core (input sclk_rise, input sclk_fall, input sdi, input selected,
                input deselect, input paused, input guard_n);
endinterface : fph_link_if
`default_nettype wire

// ### verilog/fph_pin_front.sv
// Pin synchronisers, serial clock edge finder and pause tracking
`timescale 1ns/10ps
`default_nettype none
module fph_pin_front
  import fph_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_b,
  input  wire logic  chip_enable_n,
  input  wire logic  serial_clk,
  input  wire logic  serial_in,
  input  wire logic  pause_n,
  input  wire logic  guard_pin_n,
  fph_link_if.fe     lnk
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] filt;
    logic [4:0] filt_d;
    logic       paused;
  } fph_fe_st_t;

  fph_fe_st_t q_ff;
  fph_fe_st_t nxt_q;
  logic [4:0] pins;

  assign pins = {guard_pin_n, pause_n, serial_in, serial_clk, chip_enable_n};

  ////////////////////////////////////////////////////////////////////////////
  // Next state: three stages, a change counts once stage two and three agree
  always_comb begin
    nxt_q        = q_ff;
    nxt_q.s1     = pins;
    nxt_q.s2     = q_ff.s1;
    nxt_q.s3     = q_ff.s2;
    nxt_q.filt_d = q_ff.filt;
    for (int i = 0; i < 5; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.filt[i] = q_ff.s3[i];
      end
    end
    // Pause follows its pin only while the serial clock is low
    if (q_ff.filt[PIN_CS]) begin
      nxt_q.paused = 1'b0;
    end else if (!q_ff.filt[PIN_CLK]) begin
      nxt_q.paused = !q_ff.filt[PIN_PAUSE];
    end
  end

  // Register the whole state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, filt: PIN_IDLE, filt_d: PIN_IDLE, paused: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edges are withheld while paused, so clock and data are ignored
  assign lnk.selected  = !q_ff.filt[PIN_CS];
  assign lnk.deselect  = q_ff.filt[PIN_CS] && !q_ff.filt_d[PIN_CS];
  assign lnk.paused    = q_ff.paused;
  assign lnk.sclk_rise = lnk.selected && !q_ff.paused
                         && q_ff.filt[PIN_CLK] && !q_ff.filt_d[PIN_CLK];
  assign lnk.sclk_fall = lnk.selected && !q_ff.paused
                         && !q_ff.filt[PIN_CLK] && q_ff.filt_d[PIN_CLK];
  assign lnk.sdi       = q_ff.filt[PIN_SDI];
  assign lnk.guard_n   = q_ff.filt[PIN_GUARD];

endmodule : fph_pin_front
`default_nettype wire

// ### verilog/fph_flash_ctrl.sv
// Serial flash control core: power modes, status, guarding, pause and array
// Behaviour
// - Deselect stays active until internal cycle ends
// - Sleep command enters deep power-down until wake
// - In deep power-down only wake is obeyed
// - Busy flag reports running internal cycle
// - Busy reads one during cycle, else zero
// - Latch flag mirrors write enable latch
// - Latch clear refuses status-write, program, erase
// - Guard bits retained, select shielded array part
// - Lock plus guard pin freezes status bits
// - Hard guard when lock set, pin low
// - Modifying commands need whole bytes of clocks
// - Modifying commands need latch set first
// - Latch clears at reset and listed completions
// - Guard decode: none, sector 3, 2-3, all
// - Chip clear only with both guard bits zero
// - Pause never disturbs a running cycle
// - Pause starts at pin fall with clock low
// - Pause ends at pin rise with clock low
// - Paused: output floats, inputs ignored
// - Deselect while paused drops the instruction
// - 256 KiB array, four sectors, 256-byte pages
// - Program clears bits, erase by sector/chip
`timescale 1ns/10ps
`default_nettype none
module fph_flash_ctrl
  import fph_pkg::*;
#(
  parameter int ARR_BYTES  = ARRAY_BYTES,
  parameter int SECT_BYTES = SECTOR_BYTES,
  parameter int PG_BYTES   = PAGE_BYTES
) (
  input  wire logic  clock,
  input  wire logic  rst_b,
  input  wire logic  chip_enable_n,
  input  wire logic  serial_clk,
  input  wire logic  serial_in,
  input  wire logic  pause_n,
  input  wire logic  guard_pin_n,
  output logic       serial_out,
  output logic       serial_out_oe,
  output logic       busy_flag,
  output fph_power_t power_mode
);

  localparam int ADDR_W = $clog2(ARR_BYTES);
  localparam int PAGE_W = $clog2(PG_BYTES);

  typedef struct packed {
    logic [6:0]          shift;
    logic [2:0]          bitcnt;
    logic [2:0]          bytecnt;
    logic [7:0]          opcode;
    logic [23:0]         addr;
    logic [7:0]          sr_data;
    logic [7:0]          out_sr;
    logic                out_on;
    logic                sout;
    logic                latch;
    logic                lock;
    logic                guard_hi;
    logic                guard_lo;
    logic                sleep;
    fph_cycle_t          cyc;
    logic [ADDR_W-1:0]   cnt;
    logic [ADDR_W-1:0]   base;
    logic [PG_BYTES-1:0] pmask;
  } fph_core_st_t;

  fph_core_st_t      q_ff;
  fph_core_st_t      nxt_q;
  fph_link_if        lnk ();

  // Array and page staging buffer
  logic [7:0]        mem  [ARR_BYTES];
  logic [7:0]        pbuf [PG_BYTES];
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic              pbuf_we;
  logic [PAGE_W-1:0] pbuf_wa;
  logic [7:0]        pbuf_wd;

  logic [7:0]        status_byte;
  logic              hard_guard;
  logic              idle;
  logic [7:0]        in_byte;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] walk_len;
  logic              walk_last;
  logic              cmd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Pin front end
  fph_pin_front u_front (
    .clock         (clock),
    .rst_b         (rst_b),
    .chip_enable_n (chip_enable_n),
    .serial_clk    (serial_clk),
    .serial_in     (serial_in),
    .pause_n       (pause_n),
    .guard_pin_n   (guard_pin_n),
    .lnk           (lnk.fe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status byte is built live so a read shows the present latch and busy state
  always_comb begin
    status_byte                  = 8'h00;
    status_byte[ST_BUSY_POS]     = (q_ff.cyc != CYC_IDLE);
    status_byte[ST_LATCH_POS]    = q_ff.latch;
    status_byte[ST_GUARD_LO_POS] = q_ff.guard_lo;
    status_byte[ST_GUARD_HI_POS] = q_ff.guard_hi;
    status_byte[ST_LOCK_POS]     = q_ff.lock;
  end

  assign hard_guard = q_ff.lock && !lnk.guard_n;
  assign idle       = (q_ff.cyc == CYC_IDLE);
  assign in_byte    = {q_ff.shift, lnk.sdi};

  // Length of the running walk over the array
  always_comb begin
    case (q_ff.cyc)
      CYC_STATUS:  walk_len = ADDR_W'(STATUS_WRITE_CYC);
      CYC_PROGRAM: walk_len = ADDR_W'(PG_BYTES);
      CYC_SECTOR:  walk_len = ADDR_W'(SECT_BYTES);
      default:     walk_len = ADDR_W'(ARR_BYTES - 1);
    endcase
  end
  // Chip walk ends on the top address since the full size does not fit
  assign walk_last = (q_ff.cyc == CYC_CHIP) ? (q_ff.cnt == walk_len) : (q_ff.cnt == walk_len - 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_q   = q_ff;
    mem_we  = 1'b0;
    mem_wa  = q_ff.base + q_ff.cnt;
    mem_wd  = 8'hff;
    pbuf_we = 1'b0;
    pbuf_wa = q_ff.addr[PAGE_W-1:0];
    pbuf_wd = in_byte;
    rd_addr = q_ff.addr[ADDR_W-1:0];
    cmd_ok  = (q_ff.bitcnt == 3'h0) && (q_ff.bytecnt != 3'h0) && !lnk.paused;

    // Input bits on rising clock, output bits on falling clock
    if (lnk.sclk_rise) begin
      nxt_q.shift  = in_byte[6:0];
      nxt_q.bitcnt = q_ff.bitcnt + 3'h1;
      if (q_ff.bitcnt == 3'h7) begin
        nxt_q.bytecnt = (q_ff.bytecnt == 3'h5) ? 3'h5 : q_ff.bytecnt + 3'h1;
        if (q_ff.bytecnt == 3'h0) begin
          nxt_q.opcode = in_byte;
          if (in_byte == CMD_PAGE_WRITE && idle) begin
            nxt_q.pmask = '0;
          end
          if (in_byte == CMD_STATUS_READ && !q_ff.sleep) begin
            nxt_q.out_sr = status_byte;
            nxt_q.out_on = 1'b1;
          end
        end else begin
          if (q_ff.bytecnt <= 3'h3) begin
            nxt_q.addr = {q_ff.addr[15:0], in_byte};
          end
          // Held while busy, so a status poll cannot alter a running status write
          if (q_ff.bytecnt == 3'h1 && idle) begin
            nxt_q.sr_data = in_byte;
          end
          if (q_ff.bytecnt == 3'h3) begin
            rd_addr = ADDR_W'({q_ff.addr[15:0], in_byte});
          end
          case (q_ff.opcode)
            CMD_STATUS_READ: begin
              if (!q_ff.sleep) begin
                nxt_q.out_sr = status_byte;
                nxt_q.out_on = 1'b1;
              end
            end
            CMD_WAKE: begin
              if (q_ff.bytecnt >= 3'h3) begin
                nxt_q.out_sr = SIGNATURE;
                nxt_q.out_on = 1'b1;
              end
            end
            CMD_ARRAY_READ: begin
              // Array reads are ignored while a cycle runs
              if (q_ff.bytecnt >= 3'h3 && !q_ff.sleep && idle) begin
                nxt_q.out_sr = mem[rd_addr];
                nxt_q.out_on = 1'b1;
                nxt_q.addr   = 24'(rd_addr + 1'b1);
              end
            end
            CMD_PAGE_WRITE: begin
              // Data wraps inside the page, as a real page buffer does
              if (q_ff.bytecnt >= 3'h4 && !q_ff.sleep && idle) begin
                pbuf_we                 = 1'b1;
                nxt_q.pmask[pbuf_wa]    = 1'b1;
                nxt_q.addr[PAGE_W-1:0]  = q_ff.addr[PAGE_W-1:0] + 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
    if (lnk.sclk_fall && q_ff.out_on) begin
      nxt_q.sout   = q_ff.out_sr[7];
      nxt_q.out_sr = {q_ff.out_sr[6:0], 1'b0};
    end

    // End of frame: serial logic resets, complete commands execute
    if (lnk.deselect) begin
      nxt_q.bitcnt  = 3'h0;
      nxt_q.bytecnt = 3'h0;
      nxt_q.out_on  = 1'b0;
      if (cmd_ok) begin
        if (q_ff.opcode == CMD_WAKE) begin
          nxt_q.sleep = 1'b0;
        end else if (!q_ff.sleep && idle) begin
          case (q_ff.opcode)
            CMD_LATCH_SET:   nxt_q.latch = 1'b1;
            CMD_LATCH_CLEAR: nxt_q.latch = 1'b0;
            CMD_SLEEP_ENTER: nxt_q.sleep = 1'b1;
            CMD_STATUS_WRITE: begin
              if (q_ff.latch && !hard_guard && q_ff.bytecnt >= 3'h2) begin
                nxt_q.cyc = CYC_STATUS;
                nxt_q.cnt = '0;
              end
            end
            CMD_PAGE_WRITE: begin
              if (q_ff.latch && q_ff.bytecnt >= 3'h4
                  && !fph_guarded(q_ff.addr[17:16], q_ff.guard_hi, q_ff.guard_lo)) begin
                nxt_q.cyc  = CYC_PROGRAM;
                nxt_q.cnt  = '0;
                nxt_q.base = {q_ff.addr[ADDR_W-1:PAGE_W], PAGE_W'(0)};
              end
            end
            CMD_BLOCK_CLEAR: begin
              if (q_ff.latch && q_ff.bytecnt >= 3'h4
                  && !fph_guarded(q_ff.addr[17:16], q_ff.guard_hi, q_ff.guard_lo)) begin
                nxt_q.cyc  = CYC_SECTOR;
                nxt_q.cnt  = '0;
                nxt_q.base = {q_ff.addr[17:16], 16'h0000};
              end
            end
            CMD_CHIP_CLEAR: begin
              if (q_ff.latch && !q_ff.guard_hi && !q_ff.guard_lo) begin
                nxt_q.cyc  = CYC_CHIP;
                nxt_q.cnt  = '0;
                nxt_q.base = '0;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    // Internal cycle walk runs on regardless of pause or select
    case (q_ff.cyc)
      CYC_STATUS: begin
        if (walk_last) begin
          nxt_q.lock     = q_ff.sr_data[ST_LOCK_POS];
          nxt_q.guard_hi = q_ff.sr_data[ST_GUARD_HI_POS];
          nxt_q.guard_lo = q_ff.sr_data[ST_GUARD_LO_POS];
        end
      end
      CYC_PROGRAM: begin
        mem_we = q_ff.pmask[q_ff.cnt[PAGE_W-1:0]];
        mem_wd = mem[mem_wa] & pbuf[q_ff.cnt[PAGE_W-1:0]];
      end
      CYC_SECTOR, CYC_CHIP: begin
        mem_we = 1'b1;
      end
      default: begin
      end
    endcase
    if (!idle) begin
      nxt_q.cnt = q_ff.cnt + 1'b1;
      if (walk_last) begin
        nxt_q.cyc   = CYC_IDLE;
        nxt_q.latch = 1'b0;
      end
    end
  end

  // Register the whole state; retained bits take their stored image
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q_ff          <= '0;
      q_ff.latch    <= 1'b0;
      q_ff.lock     <= LOCK_RST;
      q_ff.guard_hi <= GUARD_RST[1];
      q_ff.guard_lo <= GUARD_RST[0];
      q_ff.cyc      <= CYC_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Array and buffer writes; storage has no reset by nature
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pbuf_we) begin
      pbuf[pbuf_wa] <= pbuf_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; output floats while paused or deselected
  assign serial_out    = q_ff.sout;
  assign serial_out_oe = lnk.selected && !lnk.paused && q_ff.out_on;
  assign busy_flag     = !idle;
  assign power_mode    = q_ff.sleep ? PWR_SLEEP
                       : ((lnk.selected || !idle) ? PWR_ACTIVE : PWR_STANDBY);

endmodule : fph_flash_ctrl
`default_nettype wire

// ### tb/fph_flash_ctrl_chk.sv
// Port-level assertion checker for the flash control top
`timescale 1ns/10ps
`default_nettype none
module fph_flash_ctrl_chk
  import fph_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       chip_enable_n,
  input wire logic       serial_clk,
  input wire logic       serial_in,
  input wire logic       pause_n,
  input wire logic       guard_pin_n,
  input wire logic       serial_out,
  input wire logic       serial_out_oe,
  input wire logic       busy_flag,
  input wire fph_power_t power_mode
);
  logic [19:0] busy_cnt_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////
  // Length of the current busy spell
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) busy_cnt_ff <= 20'h0;
    else busy_cnt_ff <= busy_flag ? busy_cnt_ff + 20'h1 : 20'h0;
  end

  ////////////////////////////////////////////////////////////////
  property p_desel_float; chip_enable_n [*8] |-> !serial_out_oe; endproperty
  a_desel_float: assert property (p_desel_float) else $error("output driven while deselected");
  property p_pause_float; (!pause_n && !serial_clk) [*8] |-> !serial_out_oe; endproperty
  a_pause_float: assert property (p_pause_float) else $error("output driven while paused");
  property p_sleep_idle; power_mode == PWR_SLEEP |-> !busy_flag; endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("busy while asleep");
  property p_busy_active; busy_flag |-> power_mode == PWR_ACTIVE; endproperty
  a_busy_active: assert property (p_busy_active) else $error("busy but not active");
  // Sync delay of the select pin is well inside eight cycles
  property p_standby; (chip_enable_n && !busy_flag) [*8] ##0 power_mode != PWR_SLEEP
    |-> power_mode == PWR_STANDBY; endproperty
  a_standby: assert property (p_standby) else $error("not standby when idle");
  // Shortest internal cycle is the status write
  property p_busy_len; $fell(busy_flag) |-> busy_cnt_ff >= 20'(STATUS_WRITE_CYC); endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy spell too short");
  property p_busy_start; $rose(busy_flag) |-> $past(chip_enable_n, 3); endproperty
  a_busy_start: assert property (p_busy_start) else $error("cycle started while selected");
  property p_sleep_hold; chip_enable_n [*8] ##0 power_mode == PWR_SLEEP |=> power_mode == PWR_SLEEP;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep without wake");
endmodule : fph_flash_ctrl_chk

bind fph_flash_ctrl fph_flash_ctrl_chk u_chk (.clock(clock), .rst_b(rst_b), .chip_enable_n(chip_enable_n),
  .serial_clk(serial_clk), .serial_in(serial_in), .pause_n(pause_n), .guard_pin_n(guard_pin_n),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .busy_flag(busy_flag), .power_mode(power_mode));
`default_nettype wire

// ### tb/fph_spi_host.sv
// Serial bus host model driving the flash control block
`timescale 1ns/10ps
`default_nettype none
module fph_spi_host (
  input  wire logic clock,
  input  wire logic serial_out,
  output var logic  chip_enable_n,
  output var logic  serial_clk,
  output var logic  serial_in,
  output var logic  pause_n
);
  ////////////////////////////////////////////////////////////////
  // Idle bus: deselected, clock parked low
  initial begin
    chip_enable_n = 1'b1;
    serial_clk    = 1'b0;
    serial_in     = 1'b0;
    pause_n       = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  ////////////////////////////////////////////////////////////////
  // One frame, MSB first, 80 ns bit; optional pause before bit pz
  task automatic xfer(input int n, input logic [47:0] d, input int pz, input bit drop, output logic [47:0] q);
    q = 48'h0;
    chip_enable_n = 1'b0;
    cyc(8);
    for (int i = n - 1; i >= 0; i--) begin
      if (i == pz) begin
        pause_n = 1'b0;
        cyc(8);
        // Noise on clock and data that must be ignored
        serial_in  = ~serial_in;
        serial_clk = 1'b1;
        cyc(4);
        serial_clk = 1'b0;
        cyc(8);
        if (drop) begin
          chip_enable_n = 1'b1;
          cyc(8);
          pause_n = 1'b1;
          cyc(8);
          return;
        end
        pause_n = 1'b1;
        cyc(8);
      end
      serial_in = d[i];
      cyc(4);
      serial_clk = 1'b1;
      cyc(4);
      q = {q[46:0], serial_out};
      serial_clk = 1'b0;
    end
    cyc(4);
    chip_enable_n = 1'b1;
    // Released data line flips, so a stale bit cannot pass
    serial_in = ~serial_in;
    cyc(10);
  endtask : xfer
endmodule : fph_spi_host
`default_nettype wire

// ### tb/fph_flash_ctrl_tb_top.sv
// Self-checking bench for the flash power and protection control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module fph_flash_ctrl_tb_top
  import fph_pkg::*;
;
  logic       clock;
  logic       rst_b;
  logic       guard_pin_n;
  wire        chip_enable_n;
  wire        serial_clk;
  wire        serial_in;
  wire        pause_n;
  logic       serial_out;
  logic       serial_out_oe;
  logic       busy_flag;
  fph_power_t power_mode;
  int         err_count;
  int         checks;

  fph_flash_ctrl dut (.clock(clock), .rst_b(rst_b), .chip_enable_n(chip_enable_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .pause_n(pause_n), .guard_pin_n(guard_pin_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .busy_flag(busy_flag), .power_mode(power_mode));
  // Released data line reads as pulled high, so a floating output cannot pass
  fph_spi_host u_host (.clock(clock), .serial_out(serial_out_oe ? serial_out : 1'b1), .chip_enable_n(chip_enable_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .pause_n(pause_n));

  ////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic cmd(input int n, input logic [47:0] d);
    logic [47:0] q;
    u_host.xfer(n, d, -1, 1'b0, q);
  endtask : cmd

  // Status read; the byte after the opcode is the status image
  task automatic st(input string nm, input logic [7:0] e);
    logic [47:0] q;
    u_host.xfer(16, 48'h0500, -1, 1'b0, q);
    `CHK(nm, e, q[7:0])
  endtask : st

  // Bounded wait for the internal cycle to end
  task automatic idle;
    int k;
    k = 0;
    while (busy_flag !== 1'b0 && k < 400) begin
      u_host.cyc(1);
      k++;
    end
    `CHK("busy end", 1'b0, busy_flag)
  endtask : idle

  ////////////////////////////////////////////////////////////////
  task automatic s_latch;
    `CHK("mode", PWR_STANDBY, power_mode)
    st("reset status", 8'h00);
    cmd(8, 48'h06);
    st("latch set", 8'h02);
    cmd(8, 48'h04);
    st("latch clear", 8'h00);
  endtask : s_latch

  task automatic s_swrite;
    cmd(16, 48'h010c);
    `CHK("no latch busy", 1'b0, busy_flag)
    st("no latch", 8'h00);
    cmd(8, 48'h06);
    cmd(15, 48'h0083);
    `CHK("odd count busy", 1'b0, busy_flag)
    st("odd count", 8'h02);
    cmd(16, 48'h0108);
    `CHK("write busy", 1'b1, busy_flag)
    idle();
    st("guard hi", 8'h08);
  endtask : s_swrite

  // Guard 10 shields sectors 2 and 3 and blocks chip clear
  task automatic s_guard;
    cmd(8, 48'h06);
    cmd(32, 48'hd8020000);
    `CHK("sector 2 clear", 1'b0, busy_flag)
    cmd(8, 48'hc7);
    `CHK("chip clear", 1'b0, busy_flag)
    cmd(40, 48'h0201000000);
    `CHK("sector 1 program", 1'b1, busy_flag)
    `CHK("mode busy", PWR_ACTIVE, power_mode)
    st("during program", 8'h0b);
    idle();
    `CHK("mode after", PWR_STANDBY, power_mode)
    st("after program", 8'h08);
  endtask : s_guard

  task automatic s_hard;
    cmd(8, 48'h06);
    cmd(16, 48'h0180);
    idle();
    guard_pin_n = 1'b0;
    cmd(8, 48'h06);
    cmd(16, 48'h0100);
    `CHK("hard guard", 1'b0, busy_flag)
    st("locked", 8'h82);
    guard_pin_n = 1'b1;
    cmd(16, 48'h0100);
    idle();
    st("unlocked", 8'h00);
  endtask : s_hard

  task automatic s_sleep;
    logic [47:0] q;
    cmd(8, 48'hb9);
    `CHK("sleep", PWR_SLEEP, power_mode)
    cmd(8, 48'h06);
    u_host.xfer(16, 48'h0500, -1, 1'b0, q);
    `CHK("sleep read", 8'hff, q[7:0])
    cmd(8, 48'hab);
    `CHK("wake", PWR_STANDBY, power_mode)
    st("ignored in sleep", 8'h00);
  endtask : s_sleep

  task automatic s_pause;
    logic [47:0] q;
    u_host.xfer(8, 48'h06, 4, 1'b0, q);
    st("paused latch set", 8'h02);
    cmd(8, 48'h04);
    // Whole opcode byte in before the drop, so only the pause can refuse it
    u_host.xfer(16, 48'h0600, 7, 1'b1, q);
    st("dropped", 8'h00);
    cmd(8, 48'h06);
    cmd(40, 48'h0200000000);
    u_host.xfer(16, 48'h0500, 6, 1'b0, q);
    `CHK("busy through pause", 8'h03, q[7:0])
    idle();
    st("after pause", 8'h00);
  endtask : s_pause

  task automatic results;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////
  // Main sequence; pins settle before the first select
  initial begin
    rst_b       = 1'b0;
    guard_pin_n = 1'b1;
    err_count   = 0;
    checks      = 0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    u_host.cyc(10);
    s_latch();
    s_swrite();
    s_guard();
    s_hard();
    s_sleep();
    s_pause();
    results();
  end

  // Watchdog, about six and a half times the expected run
  initial begin
    #400000;
    err_count++;
    results();
  end
endmodule : fph_flash_ctrl_tb_top
`default_nettype wire
